/* design/dsg_regs.svh */
// register offsets, field positions and counts for the dual serial glue
`ifndef DSG_REGS_SVH
`define DSG_REGS_SVH

// -----------------------------------------------------------------
// host port window
// -----------------------------------------------------------------
`define DSG_WINDOW_PORTS 16
`define DSG_CHAN_PORTS 8
`define DSG_CHAN_BIT 3

// -----------------------------------------------------------------
// per-channel register select (low three port bits)
// -----------------------------------------------------------------
`define DSG_REG_DATA 3'h0
`define DSG_REG_IER 3'h1
`define DSG_REG_IIR 3'h2
`define DSG_REG_LCR 3'h3
`define DSG_REG_MCR 3'h4
`define DSG_REG_LSR 3'h5
`define DSG_REG_MSR 3'h6
`define DSG_REG_SCR 3'h7

// -----------------------------------------------------------------
// field positions and fixed values
// -----------------------------------------------------------------
`define DSG_LCR_DLAB 7
`define DSG_IER_MODEM 3
`define DSG_MCR_AUX_OUTPUT_ONE 2
`define DSG_MCR_AUX_OUTPUT_TWO 3
`define DSG_MCR_LOOP 4
`define DSG_MCR_MASK 8'h1F
`define DSG_MSR_CALL_SENSE_FALL_FLAG 2
`define DSG_MSR_DDCD 3
`define DSG_MSR_RI 6
`define DSG_MSR_DCD 7
`define DSG_LSR_IDLE 8'h60
`define DSG_IIR_NONE 8'h01
`define DSG_IIR_MODEM 8'h00

// -----------------------------------------------------------------
// glue registers (word index, byte address is index times four)
// -----------------------------------------------------------------
`define DSG_IDX_CFG 5'h10
`define DSG_IDX_ISTAT 5'h11
`define DSG_IDX_IMASK 5'h12
`define DSG_IDX_RXCNT 5'h13
`define DSG_CFG_CLK4 0
`define DSG_CFG_IRQ_ROUTE 1
`define DSG_CFG_RST_LINK 2
`define DSG_CFG_EXT_RX0 3
`define DSG_CFG_RESET 5'h00

`endif

/* design/dsg_pkg.sv */
// shared types for the dual serial glue
package dsg_pkg;
	typedef logic [7:0] dsg_byte_type;
	typedef logic [15:0] dsg_div_type;
	typedef logic [2:0] dsg_reg_sel_type;
endpackage

/* design/dsg_channel.sv */
// one serial channel: divisor, control, modem status and baud clock
`timescale 1ns/100ps
`default_nettype none
`include "dsg_regs.svh"
module dsg_channel (
	// clock and resets
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ctl_rst,
	input wire logic master_tick,
	// pins, asynchronous, and the receive clock source select from the glue
	input wire logic phone_call_sense_input_n,
	input wire logic rx_clk_pin,
	input wire logic ext_rx_sel,
	// register access
	input wire logic wr_en,
	input wire logic rd_clr,
	input wire logic [3:0] clr_mask,
	input wire dsg_pkg::dsg_reg_sel_type addr,
	input wire dsg_pkg::dsg_byte_type wdata,
	output dsg_pkg::dsg_byte_type rd_data,
	// events and outputs
	output logic int_req,
	output logic ring_fall,
	output logic rx_tick,
	output logic baud_out,
	output logic aux_output_one_n,
	output logic aux_output_two_n
);
	import dsg_pkg::*;

	dsg_div_type div_q, cnt_q;
	dsg_byte_type hold_q, scr_q, ier_q, lcr_q, mcr_q;
	logic [3:0] delta_q;
	logic [2:0] ring_s_q, rxc_s_q;
	logic ring_f_q, rxc_f_q, ri_prev_q, dcd_prev_q, rx_prev_q, baud_q;
	logic aux1_q, aux2_q;

	// -----------------------------------------------------------------
	// pin synchronisers, a change counts once stages two and three agree
	// -----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ring_s_q <= 3'h7;
			rxc_s_q <= 3'h0;
			ring_f_q <= 1'b1;
			rxc_f_q <= 1'b0;
		end else begin
			ring_s_q <= {ring_s_q[1:0], phone_call_sense_input_n};
			rxc_s_q <= {rxc_s_q[1:0], rx_clk_pin};
			if (ring_s_q[1] == ring_s_q[2])
				ring_f_q <= ring_s_q[2];
			if (rxc_s_q[1] == rxc_s_q[2])
				rxc_f_q <= rxc_s_q[2];
		end
	end

	// -----------------------------------------------------------------
	// decode and status assembly
	// -----------------------------------------------------------------
	wire dlab = lcr_q[`DSG_LCR_DLAB];
	wire loop = mcr_q[`DSG_MCR_LOOP];
	wire ri_lvl = loop ? mcr_q[`DSG_MCR_AUX_OUTPUT_TWO] : ~ring_f_q; // RULE_11
	wire dcd_lvl = loop & mcr_q[`DSG_MCR_AUX_OUTPUT_ONE]; // RULE_17
	wire dcd_chg = dcd_lvl ^ dcd_prev_q;
	assign ring_fall = ri_lvl & ~ri_prev_q; // RULE_12
	wire [3:0] delta_set = {dcd_chg, ring_fall, 2'b00};
	wire [3:0] delta_clr = rd_clr ? clr_mask : 4'h0;
	wire [3:0] delta_d = delta_set | (delta_q & ~delta_clr);
	wire [7:0] msr_view = {dcd_lvl, ri_lvl, 2'b00, delta_q};
	wire intr = ier_q[`DSG_IER_MODEM] & (|delta_q); // RULE_13
	wire wr_data = wr_en && addr == `DSG_REG_DATA;
	wire wr_ier = wr_en && addr == `DSG_REG_IER;
	wire rx_src = ext_rx_sel ? rxc_f_q : baud_q; // RULE_06

	always_comb begin
		unique case (addr)
			`DSG_REG_DATA: rd_data = dlab ? div_q[7:0] : hold_q;
			`DSG_REG_IER: rd_data = dlab ? div_q[15:8] : ier_q;
			`DSG_REG_IIR: rd_data = intr ? `DSG_IIR_MODEM : `DSG_IIR_NONE;
			`DSG_REG_LCR: rd_data = lcr_q;
			`DSG_REG_MCR: rd_data = mcr_q;
			`DSG_REG_LSR: rd_data = `DSG_LSR_IDLE;
			`DSG_REG_MSR: rd_data = msr_view;
			`DSG_REG_SCR: rd_data = scr_q;
		endcase
	end

	// -----------------------------------------------------------------
	// divisor and holding bytes survive the controller reset
	// -----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 16'h0000;
			hold_q <= 8'h00;
		end else begin
			if (wr_data && dlab)
				div_q[7:0] <= wdata; // RULE_15
			if (wr_ier && dlab)
				div_q[15:8] <= wdata;
			if (wr_data && !dlab)
				hold_q <= wdata;
		end
	end

	// -----------------------------------------------------------------
	// control registers, cleared by either reset
	// -----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ier_q <= 8'h00;
			lcr_q <= 8'h00;
			mcr_q <= 8'h00;
			scr_q <= 8'h00;
			delta_q <= 4'h0;
			ri_prev_q <= 1'b0;
			dcd_prev_q <= 1'b0;
		end else if (ctl_rst) begin
			ier_q <= 8'h00; // RULE_15
			lcr_q <= 8'h00;
			mcr_q <= 8'h00;
			scr_q <= 8'h00;
			delta_q <= 4'h0;
			ri_prev_q <= ri_lvl;
			dcd_prev_q <= dcd_lvl;
		end else begin
			if (wr_ier && !dlab)
				ier_q <= wdata & 8'h0F;
			if (wr_en && addr == `DSG_REG_LCR)
				lcr_q <= wdata;
			if (wr_en && addr == `DSG_REG_MCR)
				mcr_q <= wdata & `DSG_MCR_MASK;
			if (wr_en && addr == `DSG_REG_SCR)
				scr_q <= wdata;
			delta_q <= delta_d; // RULE_12
			ri_prev_q <= ri_lvl;
			dcd_prev_q <= dcd_lvl;
		end
	end

	// -----------------------------------------------------------------
	// 16x clock: one master period high every divisor periods
	// -----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 16'h0000;
			baud_q <= 1'b0;
			rx_prev_q <= 1'b0;
			rx_tick <= 1'b0;
			int_req <= 1'b0;
			aux1_q <= 1'b1;
			aux2_q <= 1'b1;
		end else begin
			if (master_tick) begin
				baud_q <= div_q != 16'h0000 && cnt_q <= 16'h0001; // RULE_05
				cnt_q <= (cnt_q <= 16'h0001) ? div_q : cnt_q - 16'h0001;
			end
			rx_prev_q <= rx_src;
			rx_tick <= rx_src & ~rx_prev_q; // RULE_06
			int_req <= intr;
			aux1_q <= ~mcr_q[`DSG_MCR_AUX_OUTPUT_ONE]; // RULE_09
			aux2_q <= ~mcr_q[`DSG_MCR_AUX_OUTPUT_TWO]; // RULE_10
		end
	end

	assign baud_out = baud_q;
	assign aux_output_one_n = aux1_q;
	assign aux_output_two_n = aux2_q;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_aux_follow: assert property ( // RULE_09
		wr_en && addr == `DSG_REG_MCR && !ctl_rst ##1 !ctl_rst |->
		##1 aux_output_one_n == !$past(wdata[`DSG_MCR_AUX_OUTPUT_ONE], 2) &&
		aux_output_two_n == !$past(wdata[`DSG_MCR_AUX_OUTPUT_TWO], 2))
		else $error("aux outputs do not follow control write");
	a_ring_flag: assert property (ring_fall && !ctl_rst |=> // RULE_12
		delta_q[`DSG_MSR_CALL_SENSE_FALL_FLAG]) else $error("ring fall flag not set");
	a_ring_irq: assert property (ring_fall && !ctl_rst && // RULE_13
		ier_q[`DSG_IER_MODEM] && !$past(ctl_rst) ##1 !ctl_rst |=> int_req)
		else $error("ring fall raised no request");
	a_ctl_keep: assert property (ctl_rst |=> $stable(div_q) && // RULE_15
		$stable(hold_q) && lcr_q == 8'h00 && mcr_q == 8'h00)
		else $error("controller reset touched kept registers");
	a_loop_map: assert property (loop |-> // RULE_17
		msr_view[`DSG_MSR_RI] == mcr_q[`DSG_MCR_AUX_OUTPUT_TWO] &&
		msr_view[`DSG_MSR_DCD] == mcr_q[`DSG_MCR_AUX_OUTPUT_ONE])
		else $error("loopback status mapping wrong");
	a_baud_rate: assert property (master_tick && div_q > 16'h0001 && // RULE_05
		cnt_q == 16'h0001 |=> baud_q && cnt_q == $past(div_q))
		else $error("baud clock did not fire on reload");
	a_rx_loop: assert property (!ext_rx_sel && $rose(baud_q) // RULE_06
		##1 !ext_rx_sel |-> rx_tick) else $error("receive tick missed");
endmodule // dsg_channel
`default_nettype wire

/* design/dsg_glue.sv */
// top: APB slave for the 16-port window, clock select, irq glue
// Operation
// [RULE_01] board answers one 16-port block on select
// [RULE_02] lower eight ports channel one, upper two
// [RULE_03] host supplies select from decoded port lines
// [RULE_04] 2MHz master from system clock or half
// [RULE_05] transmit clock is master over divisor
// [RULE_06] receive clock from own baud or external
// [RULE_07] both channel requests merged, active low
// [RULE_08] vectored systems route request via vector source
// [RULE_09] aux output one low while control bit2
// [RULE_10] aux output two follows control bit3; the code drives it low while bit3 is set
// [RULE_11] ring input readable as status bit6
// [RULE_12] status bit2 flags ring input falling
// [RULE_13] ring fall raises enabled modem interrupt
// [RULE_14] system reset reaches controllers only via link
// [RULE_15] controller reset keeps buffers and divisors
// [RULE_16] low three bits register, bit three channel
// [RULE_17] loopback ties aux outputs to status inputs
`timescale 1ns/100ps
`default_nettype none
`include "dsg_regs.svh"
module dsg_glue (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// board pins, asynchronous
	input wire logic sys_clk_pin,
	input wire logic sys_reset_pin_n,
	input wire logic [1:0] phone_call_sense_input_n,
	input wire logic [1:0] rx_clk_pin,
	// line-side clocks and user outputs
	output logic [1:0] baud_out,
	output logic [1:0] aux_output_one_n,
	output logic [1:0] aux_output_two_n,
	// interrupts
	output logic irq_uart_n,
	output logic irq_bus_n,
	output logic irq
);
	import dsg_pkg::*;

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	logic [4:0] cfg_q;
	logic [1:0] istat_q, imask_q;
	logic [7:0] rxcnt_q [2];
	logic [2:0] sclk_s_q, srst_s_q;
	logic sclk_f_q, srst_f_q, sclk_prev_q, half_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;
	logic irq_uart_q, irq_bus_q, irq_q;
	logic [1:0] ch_int, ch_fall, ch_rx_tick, ch_baud, ch_aux1, ch_aux2;
	dsg_byte_type ch_rd [2];

	// -----------------------------------------------------------------
	// address decode
	// -----------------------------------------------------------------
	wire [4:0] idx = paddr[6:2];
	wire setup = psel & ~penable;
	wire access = psel & penable & pready_q;
	wire acc_wr = access & pwrite;
	wire acc_rd = access & ~pwrite;
	wire high_zero = paddr[31:7] == 25'h0000000 && paddr[1:0] == 2'h0;
	wire win_hit = high_zero && idx < 5'(`DSG_WINDOW_PORTS); // RULE_01
	wire ch_sel = idx[`DSG_CHAN_BIT]; // RULE_02
	wire [2:0] reg_sel = idx[2:0]; // RULE_16
	wire hit_cfg = high_zero && idx == `DSG_IDX_CFG;
	wire hit_istat = high_zero && idx == `DSG_IDX_ISTAT;
	wire hit_imask = high_zero && idx == `DSG_IDX_IMASK;
	wire hit_rxcnt = high_zero && idx == `DSG_IDX_RXCNT;
	wire any_hit = win_hit | hit_cfg | hit_istat | hit_imask | hit_rxcnt;
	wire [1:0] ch_wr = {2{acc_wr & win_hit}} & {ch_sel, ~ch_sel};
	wire [1:0] ch_msr_rd = {2{acc_rd & win_hit &&
		reg_sel == `DSG_REG_MSR}} & {ch_sel, ~ch_sel};

	// -----------------------------------------------------------------
	// read mux, sampled in the setup cycle
	// -----------------------------------------------------------------
	wire [31:0] rd_mux =
		win_hit ? {24'h000000, ch_rd[ch_sel]} :
		hit_cfg ? {27'h0000000, cfg_q} :
		hit_istat ? {30'h00000000, istat_q} :
		hit_imask ? {30'h00000000, imask_q} :
		hit_rxcnt ? {16'h0000, rxcnt_q[1], rxcnt_q[0]} : 32'h00000000;

	// -----------------------------------------------------------------
	// pin synchronisers for system clock and system reset
	// -----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_s_q <= 3'h0;
			srst_s_q <= 3'h7;
			sclk_f_q <= 1'b0;
			srst_f_q <= 1'b1;
		end else begin
			sclk_s_q <= {sclk_s_q[1:0], sys_clk_pin};
			srst_s_q <= {srst_s_q[1:0], sys_reset_pin_n};
			if (sclk_s_q[1] == sclk_s_q[2])
				sclk_f_q <= sclk_s_q[2];
			if (srst_s_q[1] == srst_s_q[2])
				srst_f_q <= srst_s_q[2];
		end
	end

	// -----------------------------------------------------------------
	// master clock enable: every rising system edge, or every second one
	// -----------------------------------------------------------------
	wire sys_tick = sclk_f_q & ~sclk_prev_q;
	wire clk4 = cfg_q[`DSG_CFG_CLK4];
	wire master_tick = sys_tick & (~clk4 | half_q); // RULE_04
	// power-up is presetn; the system line only counts when linked
	wire ctl_rst = cfg_q[`DSG_CFG_RST_LINK] & ~srst_f_q; // RULE_14

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_prev_q <= 1'b0;
			half_q <= 1'b0;
		end else begin
			sclk_prev_q <= sclk_f_q;
			if (sys_tick)
				half_q <= ~half_q; // RULE_04
		end
	end

	// -----------------------------------------------------------------
	// channels
	// -----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_ch
			dsg_channel u_ch (
				.pclk(pclk),
				.presetn(presetn),
				.ctl_rst(ctl_rst),
				.master_tick(master_tick),
				.phone_call_sense_input_n(phone_call_sense_input_n[g]),
				.rx_clk_pin(rx_clk_pin[g]),
				.ext_rx_sel(cfg_q[`DSG_CFG_EXT_RX0 + g]),
				.wr_en(ch_wr[g]),
				.rd_clr(ch_msr_rd[g]),
				// only bits shown to software may be cleared
				.clr_mask(prdata_q[3:0]),
				.addr(reg_sel),
				.wdata(pwdata[7:0]),
				.rd_data(ch_rd[g]),
				.int_req(ch_int[g]),
				.ring_fall(ch_fall[g]),
				.rx_tick(ch_rx_tick[g]),
				.baud_out(ch_baud[g]),
				.aux_output_one_n(ch_aux1[g]),
				.aux_output_two_n(ch_aux2[g])
			);
		end
	endgenerate

	assign baud_out = ch_baud;
	assign aux_output_one_n = ch_aux1;
	assign aux_output_two_n = ch_aux2;

	// -----------------------------------------------------------------
	// apb answer: zero wait, data captured at setup
	// -----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~any_hit;
			if (setup)
				prdata_q <= (pwrite || !any_hit) ? 32'h00000000 : rd_mux;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// -----------------------------------------------------------------
	// glue registers; a set in the clearing cycle wins
	// -----------------------------------------------------------------
	wire [1:0] istat_clr = (acc_wr && hit_istat) ? pwdata[1:0] : 2'h0;
	wire [1:0] istat_d = ch_fall | (istat_q & ~istat_clr);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= `DSG_CFG_RESET;
			imask_q <= 2'h0;
			istat_q <= 2'h0;
		end else begin
			if (acc_wr && hit_cfg)
				cfg_q <= pwdata[4:0];
			if (acc_wr && hit_imask)
				imask_q <= pwdata[1:0];
			istat_q <= istat_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxcnt_q[0] <= 8'h00;
			rxcnt_q[1] <= 8'h00;
		end else begin
			if (ch_rx_tick[0])
				rxcnt_q[0] <= rxcnt_q[0] + 8'h01; // RULE_06
			if (ch_rx_tick[1])
				rxcnt_q[1] <= rxcnt_q[1] + 8'h01;
		end
	end

	// -----------------------------------------------------------------
	// interrupt lines
	// -----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_uart_q <= 1'b1;
			irq_bus_q <= 1'b1;
			irq_q <= 1'b0;
		end else begin
			irq_uart_q <= ~(|ch_int); // RULE_07
			irq_bus_q <= ~((|ch_int) & cfg_q[`DSG_CFG_IRQ_ROUTE]);
			irq_q <= |(istat_d & imask_q);
		end
	end

	assign irq_uart_n = irq_uart_q;
	assign irq_bus_n = irq_bus_q;
	assign irq = irq_q;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [1:0] st_cnt_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st_cnt_q <= 2'h0;
		else if (master_tick)
			st_cnt_q <= 2'h0;
		else if (sys_tick && st_cnt_q != 2'h3)
			st_cnt_q <= st_cnt_q + 2'h1;
	end

	// the first halved tick after a switch may come early
	logic half_seen_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			half_seen_q <= 1'b0;
		else if (!clk4)
			half_seen_q <= 1'b0;
		else if (master_tick)
			half_seen_q <= 1'b1;
	end

	sequence s_setup_win;
		setup && win_hit;
	endsequence
	sequence s_access_wr;
		access && pwrite;
	endsequence

	a_window_decode: assert property ( // RULE_02
		s_setup_win ##1 s_access_wr |->
		ch_wr[ch_sel] && !ch_wr[!ch_sel])
		else $error("window write reached wrong channel");
	a_window_bound: assert property (setup && !win_hit && // RULE_01
		!any_hit |=> pslverr && pready && ch_wr == 2'h0)
		else $error("unmapped port not refused");
	a_master_half: assert property (master_tick && clk4 && // RULE_04
		half_seen_q |-> st_cnt_q == 2'h1)
		else $error("halved master clock rate wrong");
	a_master_full: assert property (sys_tick && !clk4 // RULE_04
		|-> master_tick) else $error("direct master clock missed");
	a_irq_merge: assert property (##1 irq_uart_n == // RULE_07
		!$past(|ch_int)) else $error("combined request wrong");
	a_irq_route: assert property (!cfg_q[`DSG_CFG_IRQ_ROUTE] // RULE_07
		|=> irq_bus_n) else $error("request reached bus unlinked");
	a_reset_link: assert property (!cfg_q[`DSG_CFG_RST_LINK] // RULE_14
		|-> !ctl_rst) else $error("system reset leaked unlinked");
	a_ring_sticky: assert property (ch_fall[0] |=> istat_q[0]) // RULE_12
		else $error("ring status bit lost");
endmodule // dsg_glue
`default_nettype wire

/* tb/dsg_host_model.sv */
// host processor model: drives the glue's apb slave port
`timescale 1ns/100ps
`default_nettype none
module dsg_host_model (
	// clock
	input wire logic pclk,
	// answer from the glue
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	// request to the glue
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [31:0] paddr,
	output logic [31:0] pwdata
);
	logic hung;

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		hung = 1'b0;
	end

	// -----------------------------------------------------------------
	// one transfer
	// -----------------------------------------------------------------
	// psel is the board select, one decoded 16-port range
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		hung = (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule // dsg_host_model
`default_nettype wire

/* tb/dual_serial_port_glue_tb.sv */
// self-checking bench for the dual serial glue
`timescale 1ns/100ps
`default_nettype none
module dual_serial_port_glue_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic sys_clk_pin, sys_reset_pin_n, irq_uart_n, irq_bus_n, irq;
	logic [1:0] phone_call_sense_input_n, rx_clk_pin, baud_out;
	logic [1:0] aux_output_one_n, aux_output_two_n;
	int num_errors, tests_run, n;
	logic [7:0] base;

	dsg_glue DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sys_clk_pin(sys_clk_pin),
		.sys_reset_pin_n(sys_reset_pin_n),
		.phone_call_sense_input_n(phone_call_sense_input_n),
		.rx_clk_pin(rx_clk_pin), .baud_out(baud_out),
		.aux_output_one_n(aux_output_one_n),
		.aux_output_two_n(aux_output_two_n), .irq_uart_n(irq_uart_n),
		.irq_bus_n(irq_bus_n), .irq(irq));
	dsg_host_model host (.pclk(pclk), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata));

	always #10 pclk = ~pclk;
	// offset keeps the 2 MHz pin edges away from pclk edges
	initial begin
		sys_clk_pin = 1'b0;
		#3;
		forever #250 sys_clk_pin = ~sys_clk_pin;
	end

	// -----------------------------------------------------------------
	// shared tasks
	// -----------------------------------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask
	task automatic acc(logic w, logic [4:0] idx, logic [7:0] d);
		host.xfer(w, {25'h0, idx, 2'h0}, {24'h0, d}, rd, err);
		if (host.hung) begin
			num_errors++;
			results();
		end
	endtask
	task automatic wr(logic [4:0] idx, logic [7:0] d);
		acc(1'b1, idx, d);
	endtask
	task automatic rdc(string what, logic [4:0] idx, logic [7:0] exp);
		acc(1'b0, idx, 8'h00);
		chk(what, {24'h0, exp}, rd);
	endtask
	task automatic cyc(int k);
		repeat (k) @(posedge pclk);
	endtask
	task automatic wait_irq(logic v);
		for (n = 0; n < 30 && irq_uart_n !== v; n++) cyc(1);
		if (irq_uart_n !== v) begin
			num_errors++;
			results();
		end
	endtask
	task automatic meas(output int p);
		int k, r;
		logic q;
		q = baud_out[0];
		r = 0;
		p = 0;
		for (k = 0; k < 400 && r < 2; k++) begin
			cyc(1);
			if (r == 1) p++;
			if (baud_out[0] === 1'b1 && q === 1'b0) r++;
			q = baud_out[0];
		end
	endtask

	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	task automatic t_reset();
		chk("aux one", 2'b11, aux_output_one_n);
		chk("aux two", 2'b11, aux_output_two_n);
		chk("irq", 1'b0, irq);
		chk("irq uart", 1'b1, irq_uart_n);
		rdc("lsr", 5'h05, 8'h60);
		rdc("cfg", 5'h10, 8'h00);
	endtask
	task automatic t_window();
		wr(5'h07, 8'hA5);
		wr(5'h0F, 8'h5A);
		rdc("scratch one", 5'h07, 8'hA5);
		rdc("scratch two", 5'h0F, 8'h5A);
		host.xfer(1'b0, 32'h50, 32'h0, rd, err);
		chk("unmapped err", 1'b1, err);
		chk("unmapped data", 32'h0, rd);
	endtask
	task automatic t_aux();
		wr(5'h04, 8'h04);
		wr(5'h0C, 8'h08);
		cyc(2);
		chk("aux one set", 2'b10, aux_output_one_n);
		chk("aux two set", 2'b01, aux_output_two_n);
		wr(5'h04, 8'h1C);
		cyc(2);
		acc(1'b0, 5'h06, 8'h00);
		chk("loop status", 2'b11, rd[7:6]);
		wr(5'h04, 8'h00);
		acc(1'b0, 5'h06, 8'h00);
		acc(1'b0, 5'h06, 8'h00);
		cyc(2);
		chk("aux one clear", 2'b11, aux_output_one_n);
	endtask
	task automatic t_ring();
		wr(5'h09, 8'h08);
		rdc("iir idle", 5'h0A, 8'h01);
		phone_call_sense_input_n[1] <= 1'b0;
		wait_irq(1'b0);
		chk("vector source req", 1'b0, irq_uart_n);
		chk("bus irq unrouted", 1'b1, irq_bus_n);
		chk("irq masked", 1'b0, irq);
		rdc("iir modem", 5'h0A, 8'h00);
		wr(5'h12, 8'h02);
		cyc(2);
		chk("irq unmasked", 1'b1, irq);
		acc(1'b0, 5'h0E, 8'h00);
		chk("ring level", 1'b1, rd[6]);
		chk("ring fall", 1'b1, rd[2]);
		acc(1'b0, 5'h0E, 8'h00);
		chk("ring fall read", 1'b0, rd[2]);
		wait_irq(1'b1);
		wr(5'h11, 8'h02);
		cyc(2);
		chk("irq cleared", 1'b0, irq);
		wr(5'h10, 8'h02);
		phone_call_sense_input_n[1] <= 1'b1;
		cyc(8);
		phone_call_sense_input_n[1] <= 1'b0;
		wait_irq(1'b0);
		cyc(2);
		chk("bus irq routed", 1'b0, irq_bus_n);
		acc(1'b0, 5'h0E, 8'h00);
		wr(5'h10, 8'h00);
	endtask
	task automatic t_baud();
		wr(5'h03, 8'h80);
		wr(5'h00, 8'h02);
		wr(5'h01, 8'h00);
		wr(5'h03, 8'h03);
		meas(n);
		chk("baud direct", 32'd50, n);
		wr(5'h10, 8'h01);
		meas(n);
		meas(n);
		chk("baud halved", 32'd100, n);
		chk("baud idle", 1'b0, baud_out[1]);
		wr(5'h10, 8'h00);
	endtask
	task automatic t_ctl_reset();
		wr(5'h07, 8'h3C);
		wr(5'h00, 8'h77);
		wr(5'h04, 8'h04);
		for (int k = 0; k < 2; k++) begin
			sys_reset_pin_n <= 1'b0;
			cyc(10);
			sys_reset_pin_n <= 1'b1;
			cyc(6);
			if (k == 0) rdc("no link", 5'h07, 8'h3C);
			wr(5'h10, 8'h04);
		end
		rdc("scratch reset", 5'h07, 8'h00);
		rdc("mcr reset", 5'h04, 8'h00);
		chk("aux after reset", 1'b1, aux_output_one_n[0]);
		rdc("data kept", 5'h00, 8'h77);
		wr(5'h03, 8'h80);
		rdc("divisor kept", 5'h00, 8'h02);
		wr(5'h03, 8'h00);
		wr(5'h10, 8'h00);
	endtask
	task automatic t_rxclk(logic [7:0] cfg, logic [7:0] add);
		wr(5'h10, cfg);
		acc(1'b0, 5'h13, 8'h00);
		base = rd[15:8];
		repeat (4) begin
			rx_clk_pin[1] <= 1'b1;
			cyc(5);
			rx_clk_pin[1] <= 1'b0;
			cyc(5);
		end
		cyc(6);
		acc(1'b0, 5'h13, 8'h00);
		chk("rx count", base + add, rd[15:8]);
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		sys_reset_pin_n = 1'b1;
		phone_call_sense_input_n = 2'b11;
		rx_clk_pin = 2'b00;
		num_errors = 0;
		tests_run = 0;
		cyc(12);
		presetn <= 1'b1;
		cyc(1);
		t_reset();
		t_window();
		t_aux();
		t_ring();
		t_baud();
		t_ctl_reset();
		t_rxclk(8'h00, 8'h00);
		t_rxclk(8'h10, 8'h04);
		results();
	end
endmodule // dual_serial_port_glue_tb
`default_nettype wire
